/* bench/host_model.sv */
// Host side: drives enable and the dimming line
`timescale 1ns/1ps
module host_model #(
   parameter int HALF = 160
) (
   input wire logic clk,
   input wire logic en_req,
   input wire logic dim_on,
   input wire logic pwm_mode,
   output logic enable,
   output logic dim_pwm
);
   int cnt = 0;
   logic req_q;
   logic on_q;
   logic mode_q;
   initial
   begin
      enable = 1'b0;
      dim_pwm = 1'b0;
   end
   // Half period 160 clk: above three switching periods, far above 100 Hz
   // Requests are taken on the edge, before the bench moves them
   always @(posedge clk)
   begin
      req_q = en_req;
      on_q = dim_on;
      mode_q = pwm_mode;
      #1;
      enable = req_q;
      cnt = (cnt + 1) % HALF;
      if (!mode_q)
         dim_pwm = on_q;
      else if (cnt == 0)
         dim_pwm = !dim_pwm;
   end
endmodule

/* bench/led_fault_chk.sv */
// Port-level checker for the LED boost fault supervisor
`timescale 1ns/1ps
module led_fault_chk #(
   parameter int unsigned PERIOD_CYC = led_fault_pkg::SW_PERIOD_CYC,
   parameter int unsigned ON_CYC = led_fault_pkg::SW_ON_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic dim_pwm,
   input wire led_fault_pkg::sense_s sense,
   input wire logic gate_drive,
   input wire led_fault_pkg::ch_mask_t string_en,
   input wire logic status_n,
   input wire led_fault_pkg::fault_s fault_flags
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // -----------------------------
   // Six samples cover sync plus output register
   // -----------------------------
   en_off_a: assert property (!enable [*6] |-> !gate_drive)
      else $error("gate on while disabled");
   dim_off_a: assert property (!dim_pwm [*6] |-> string_en == '0)
      else $error("string on while dimming low");
   ovp_stop_a: assert property (sense.ovp_trip [*6] |-> !gate_drive)
      else $error("gate on during overvoltage");
   vout_low_a: assert property (sense.ovp_low [*6] |-> !gate_drive)
      else $error("gate on with output shorted");
   heat_off_a: assert property ((sense.thermal || sense.supply_lockout) [*6] |-> !gate_drive)
      else $error("gate on while hot or supply low");
   abn_gate_a: assert property (fault_flags.abnormal |=> !gate_drive)
      else $error("gate on with abnormal latch");
   abn_hold_a: assert property (fault_flags.abnormal ##0 enable [*3] |=> fault_flags.abnormal)
      else $error("abnormal latch cleared without toggle");
   // Status only follows faults once enable has crossed the synchroniser
   stat_low_a: assert property ((enable [*4] ##0 (fault_flags != '0)) |-> !status_n)
      else $error("status high with fault set");
   stat_rel_a: assert property ((fault_flags == '0) [*2] |-> status_n)
      else $error("status low with no fault");
endmodule

bind led_boost_fault_supervisor led_fault_chk #(.PERIOD_CYC(PERIOD_CYC), .ON_CYC(ON_CYC))
   i_led_fault_chk (.clk(clk), .rstn(rstn), .enable(enable), .dim_pwm(dim_pwm), .sense(sense),
   .gate_drive(gate_drive), .string_en(string_en), .status_n(status_n),
   .fault_flags(fault_flags));

/* bench/tb_top.sv */
// Self-checking testbench for the LED boost fault supervisor
`timescale 1ns/1ps
module tb_top;
   localparam int P = led_fault_pkg::SW_PERIOD_CYC;
   localparam int ON = led_fault_pkg::SW_ON_CYC;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic en_req = 1'b0;
   logic dim_on = 1'b1;
   logic pwm_mode = 1'b0;
   logic enable;
   logic dim_pwm;
   led_fault_pkg::sense_s s;
   logic gate_drive;
   led_fault_pkg::ch_mask_t string_en;
   logic status_n;
   led_fault_pkg::fault_s fault_flags;
   int n_errors = 0;
   int samples_checked = 0;

   initial forever #25 clk = ~clk;

   host_model i_host_model (.clk(clk), .en_req(en_req), .dim_on(dim_on), .pwm_mode(pwm_mode),
      .enable(enable), .dim_pwm(dim_pwm));
   led_boost_fault_supervisor #(.PERIOD_CYC(P), .ON_CYC(ON)) i_led_boost_fault_supervisor (
      .clk(clk), .rstn(rstn), .enable(enable), .dim_pwm(dim_pwm), .sense(s),
      .gate_drive(gate_drive), .string_en(string_en), .status_n(status_n),
      .fault_flags(fault_flags));

   // -----------------------------
   // Helpers
   // -----------------------------
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task ons(output int c);
      c = 0;
      repeat (P)
      begin
         @(posedge clk);
         #1;
         if (gate_drive === 1'b1)
            c++;
      end
   endtask

   // Toggle clears every latch; wait out soft start
   task restart();
      s = '0;
      s.in_regulation = 1'b1;
      s.led_min_ok = 1'b1;
      en_req = 1'b0;
      tick(10);
      en_req = 1'b1;
      tick(12 * P);
   endtask

   task summarize();
      $display("Checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // -----------------------------
   // Scenarios
   // -----------------------------
   task t_run();
      int c;
      restart();
      ons(c);
      chk("run_on", 8'(c), 8'(ON));
      chk("run_str", 8'(string_en), 8'h0f);
      chk("run_stat", 8'(status_n), 8'h01);
      dim_on = 1'b0;
      tick(8);
      chk("dim_off", 8'(string_en), 8'h00);
      pwm_mode = 1'b1;
      tick(640);
      pwm_mode = 1'b0;
      dim_on = 1'b1;
      en_req = 1'b0;
      tick(8);
      ons(c);
      chk("dis_gate", 8'(c), 8'h00);
   endtask

   task t_ovp();
      int c;
      restart();
      s.ovp_trip = 1'b1;
      tick(8);
      ons(c);
      chk("ovp_gate", 8'(c), 8'h00);
      chk("ovp_flag", 8'(fault_flags.overvoltage), 8'h01);
      chk("ovp_stat", 8'(status_n), 8'h00);
      s.ovp_trip = 1'b0;
      tick(P);
      ons(c);
      chk("ovp_back", 8'(c), 8'(ON));
      s.ch_low = 4'h3;
      s.ovp_trip = 1'b1;
      tick(8);
      s.ovp_trip = 1'b0;
      s.ch_low = 4'h0;
      tick(P);
      chk("ignored", 8'(string_en), 8'h0c);
      s.ovp_low = 1'b1;
      tick(8);
      ons(c);
      chk("vout_low", 8'(c), 8'h00);
      chk("vout_flag", 8'(fault_flags.vout_short), 8'h01);
      restart();
      s.ch_low = 4'hf;
      s.ovp_trip = 1'b1;
      tick(8);
      s.ovp_trip = 1'b0;
      s.ch_low = 4'h0;
      tick(P);
      ons(c);
      chk("all_open", 8'(c), 8'h00);
      chk("open_flag", 8'(fault_flags.open_string), 8'h01);
   endtask

   task t_cs();
      int c;
      restart();
      s.cs_limit = 1'b1;
      tick(P);
      ons(c);
      chk("cs_cut", 8'((c > 0) && (c < ON)), 8'h01);
      s.cs_limit = 1'b0;
      tick(P);
      ons(c);
      chk("cs_back", 8'(c), 8'(ON));
   endtask

   task t_dshort();
      int c;
      restart();
      s.cs_short = 1'b1;
      tick(10 * P);
      s.cs_short = 1'b0;
      tick(P);
      s.cs_short = 1'b1;
      tick(14 * P);
      chk("ds_early", 8'(fault_flags.diode_short), 8'h00);
      tick(6 * P);
      s.cs_short = 1'b0;
      tick(P);
      chk("ds_latch", 8'(fault_flags.diode_short), 8'h01);
      ons(c);
      chk("ds_gate", 8'(c), 8'h00);
   endtask

   task t_short();
      restart();
      s.ch_high = 4'h4;
      s.ovp_trip = 1'b1;
      tick(8);
      chk("sh_prio", 8'(fault_flags.led_short), 8'h00);
      s.ovp_trip = 1'b0;
      s.led_min_ok = 1'b0;
      tick(8);
      chk("sh_arm", 8'(fault_flags.led_short), 8'h00);
      s.led_min_ok = 1'b1;
      tick(8);
      chk("sh_str", 8'(string_en), 8'h0b);
      s.ch_high = 4'h0;
      tick(P);
      chk("sh_hold", 8'(string_en), 8'h0b);
      restart();
      chk("sh_clr", 8'(string_en), 8'h0f);
   endtask

   task t_abn();
      int c;
      restart();
      s.ovp_abnormal = 1'b1;
      tick(4);
      s.ovp_abnormal = 1'b0;
      tick(P);
      chk("abn_flag", 8'(fault_flags.abnormal), 8'h01);
      ons(c);
      chk("abn_gate", 8'(c), 8'h00);
      restart();
      ons(c);
      chk("abn_clr", 8'(c), 8'(ON));
   endtask

   task t_heat();
      int c;
      restart();
      s.thermal = 1'b1;
      tick(8);
      ons(c);
      chk("hot", 8'(c), 8'h00);
      chk("hot_flag", 8'(fault_flags.thermal), 8'h01);
      chk("hot_stat", 8'(status_n), 8'h00);
      s.thermal = 1'b0;
      tick(8);
      ons(c);
      chk("soft", 8'(c < ON), 8'h01);
      s.supply_lockout = 1'b1;
      tick(8);
      ons(c);
      chk("lockout", 8'(c), 8'h00);
      s.supply_lockout = 1'b0;
      tick(12 * P);
      ons(c);
      chk("lock_back", 8'(c), 8'(ON));
   endtask

   initial
   begin
      s = '0;
      s.in_regulation = 1'b1;
      s.led_min_ok = 1'b1;
      tick(3);
      rstn = 1'b1;
      tick(10);
      t_run();
      t_ovp();
      t_cs();
      t_dshort();
      t_short();
      t_abn();
      t_heat();
      summarize();
   end

   // Whole sequence needs roughly 8300 clocks
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end
endmodule

/* logic/led_boost_fault_supervisor.sv */
// Enable, dimming and fault supervision for a four-string boost LED driver
// Overview of operation
// RL1: Run while enable is high; stay disabled while enable is low.
// RL2: Dimming high gives enabled strings full current; low turns all strings off.
// RL3: Host drives the dimming input at 100 Hz or faster.
// RL4: When enabled, status goes low while any listed fault is active.
// RL5: Overvoltage stops switching; resumes once sense drops by the hysteresis.
// RL6: Switch current over limit kills drive until next switching cycle.
// RL7: Channel above short threshold in operation turns its string off, latched.
// RL8: Latched shorted string clears only on supply cycle or enable toggle.
// RL9: Short detection yields to open-string and overvoltage handling.
// RL10: Short detection armed only dimming on, lowest channel above 0.1 V, post-regulation.
// RL11: On overvoltage, strings below 100 mV are ignored permanently; others continue.
// RL12: All strings open at overvoltage turns drive off and latches shutdown.
// RL13: Overvoltage sense below 0.1 V turns switch drive off.
// RL14: Shut down on supply lockout; restart when supply recovers.
// RL15: Shut down while over temperature until it cools.
// RL16: Restart from thermal shutdown goes through soft-start.
// RL17: Current above 0.8 V for over 16 switching clocks latches shutdown.
// RL18: Switch current is ignored during blanking at the start of on-time.
// RL19: Overvoltage sense above 3.2 V latches abnormal shutdown.
// RL20: Abnormal latch clears only when the host toggles enable.
// RL21: Host holds each dimming pulse at least three switching periods.
// RL22: Persistence count restarts when current drops before reaching 16.
// RL23: Status releases high when no fault is active and no latch is set.
`timescale 1ns/1ps
module led_boost_fault_supervisor #(
   parameter int unsigned PERIOD_CYC = led_fault_pkg::SW_PERIOD_CYC,
   parameter int unsigned ON_CYC = led_fault_pkg::SW_ON_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic dim_pwm,
   input wire led_fault_pkg::sense_s sense,
   output logic gate_drive,
   output led_fault_pkg::ch_mask_t string_en,
   output logic status_n,
   output led_fault_pkg::fault_s fault_flags
);

   localparam int unsigned NCH = led_fault_pkg::NUM_CH;
   localparam int unsigned SW = $bits(led_fault_pkg::sense_s) + 2;

   // ----------------------------------------------------------------
   // Reset release and input synchronisation
   // ----------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_n_ff;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   logic [SW-1:0] raw_in;
   logic [SW-1:0] sync_in;
   led_fault_pkg::sense_s s;
   logic en_s;
   logic dim_s;

   assign raw_in = {enable, dim_pwm, sense};

   sync_bank #(.WIDTH(SW)) u_sync (
      .clk(clk),
      .rst_n(rst_n_ff),
      .async_in(raw_in),
      .sync_out(sync_in)
   );

   assign en_s = sync_in[SW-1];
   assign dim_s = sync_in[SW-2];
   assign s = sync_in[SW-3:0];

   // ----------------------------------------------------------------
   // Enable toggle and switching-cycle timebase
   // ----------------------------------------------------------------
   // A low on enable clears every latch; going high again restarts soft-start
   logic [15:0] phase_ff;
   logic cycle_start;

   assign cycle_start = (phase_ff == 16'h0000);

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         phase_ff <= 16'h0000;
      else if (phase_ff == 16'(PERIOD_CYC - 1))
         phase_ff <= 16'h0000;
      else
         phase_ff <= phase_ff + 16'h0001;
   end

   // ----------------------------------------------------------------
   // Latched faults
   // ----------------------------------------------------------------
   logic abnormal_ff;
   logic all_open_ff;
   logic diode_short_ff;
   led_fault_pkg::ch_mask_t ignore_ff;
   led_fault_pkg::ch_mask_t short_ff;
   logic [4:0] persist_ff;
   logic blank_done;
   logic any_latch;
   logic open_now;
   led_fault_pkg::ch_mask_t active_ch;

   assign active_ch = ~ignore_ff & ~short_ff;
   assign open_now = |(s.ch_low & active_ch);
   assign any_latch = abnormal_ff || all_open_ff || diode_short_ff;

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         abnormal_ff <= 1'b0;
      else if (en_s && s.ovp_abnormal)
         abnormal_ff <= 1'b1; // RL19
      else if (!en_s)
         abnormal_ff <= 1'b0; // RL20
   end

   // Open strings are dropped from regulation at the overvoltage point
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         ignore_ff <= '0;
         all_open_ff <= 1'b0;
      end
      else if (!en_s)
      begin
         ignore_ff <= '0;
         all_open_ff <= 1'b0;
      end
      else if (s.ovp_trip)
      begin
         ignore_ff <= ignore_ff | (s.ch_low & ~short_ff); // RL11
         if ((s.ch_low | ignore_ff | short_ff) == {NCH{1'b1}})
            all_open_ff <= 1'b1; // RL12
      end
   end

   // Short detection: armed while dimming on and lowest channel above 0.1 V
   logic short_armed_ff;

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         short_armed_ff <= 1'b0;
      else if (!en_s || open_now)
         short_armed_ff <= 1'b0; // RL10
      else if (s.in_regulation)
         short_armed_ff <= 1'b1; // RL10
   end

   genvar c;
   generate
      for (c = 0; c < NCH; c++)
      begin : g_ch
         always_ff @(posedge clk or negedge rst_n_ff)
         begin
            if (!rst_n_ff)
               short_ff[c] <= 1'b0;
            else if (!en_s)
               short_ff[c] <= 1'b0; // RL8
            // Open-string and overvoltage handling take precedence
            else if (s.ch_high[c] && short_armed_ff && dim_s && s.led_min_ok
                     && !s.ovp_trip && !open_now && !ignore_ff[c])
               short_ff[c] <= 1'b1; // RL7 RL9 RL10
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Current sensing
   // ----------------------------------------------------------------
   logic [7:0] on_cnt_ff;
   logic limit_ff;

   assign blank_done = (on_cnt_ff >= 8'(led_fault_pkg::BLANK_CYC)); // RL18

   // Counts in switching clocks; a single drop restarts it from zero
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         persist_ff <= 5'h00;
         diode_short_ff <= 1'b0;
      end
      else if (!en_s)
      begin
         persist_ff <= 5'h00;
         diode_short_ff <= 1'b0;
      end
      else if (cycle_start)
      begin
         if (!s.cs_short)
            persist_ff <= 5'h00; // RL22
         else if (persist_ff == 5'(led_fault_pkg::SHORT_PERSIST))
            diode_short_ff <= 1'b1; // RL17
         else
            persist_ff <= persist_ff + 5'h01; // RL17
      end
   end

   // Blanked over-limit ends the pulse until the next cycle
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         limit_ff <= 1'b0;
      else if (cycle_start)
         limit_ff <= 1'b0; // RL6
      else if (gate_drive && blank_done && s.cs_limit)
         limit_ff <= 1'b1; // RL6
   end

   // ----------------------------------------------------------------
   // Run state and soft-start
   // ----------------------------------------------------------------
   led_fault_pkg::run_e state_ff;
   led_fault_pkg::run_e nxt_state;
   logic [7:0] soft_ff;
   logic shutdown;

   assign shutdown = s.supply_lockout || s.thermal; // RL14 RL15

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         led_fault_pkg::ST_OFF:
            if (en_s && !shutdown)
               nxt_state = led_fault_pkg::ST_SOFT; // RL1 RL16
         led_fault_pkg::ST_SOFT:
            if (!en_s || shutdown)
               nxt_state = led_fault_pkg::ST_OFF;
            else if (any_latch)
               nxt_state = led_fault_pkg::ST_LATCH;
            else if (soft_ff == 8'(led_fault_pkg::SOFT_PERIODS))
               nxt_state = led_fault_pkg::ST_RUN;
         led_fault_pkg::ST_RUN:
            if (!en_s || shutdown)
               nxt_state = led_fault_pkg::ST_OFF; // RL1 RL14 RL15
            else if (any_latch)
               nxt_state = led_fault_pkg::ST_LATCH;
         led_fault_pkg::ST_LATCH:
            if (!en_s)
               nxt_state = led_fault_pkg::ST_OFF; // RL20
         default:
            nxt_state = led_fault_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         state_ff <= led_fault_pkg::ST_OFF;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         soft_ff <= 8'h00;
      else if (state_ff != led_fault_pkg::ST_SOFT)
         soft_ff <= 8'h00;
      else if (cycle_start && soft_ff != 8'(led_fault_pkg::SOFT_PERIODS))
         soft_ff <= soft_ff + 8'h01; // RL16
   end

   // ----------------------------------------------------------------
   // Gate drive and string enables
   // ----------------------------------------------------------------
   logic running;
   logic [15:0] on_limit;
   logic nxt_gate;

   assign running = (state_ff == led_fault_pkg::ST_SOFT) || (state_ff == led_fault_pkg::ST_RUN);
   // Soft-start widens the on-time one step per switching period
   assign on_limit = (state_ff == led_fault_pkg::ST_SOFT)
      ? 16'((ON_CYC * (soft_ff + 1)) / (led_fault_pkg::SOFT_PERIODS + 1))
      : 16'(ON_CYC);

   always_comb
   begin
      nxt_gate = running && (phase_ff < on_limit);
      if (s.ovp_trip || s.ovp_low || limit_ff)
         nxt_gate = 1'b0; // RL5 RL13 RL6
      if (any_latch)
         nxt_gate = 1'b0; // RL12 RL17 RL19
   end

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         gate_drive <= 1'b0;
      else
         gate_drive <= nxt_gate;
   end

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         on_cnt_ff <= 8'h00;
      else if (!gate_drive)
         on_cnt_ff <= 8'h00;
      else if (on_cnt_ff != 8'hff)
         on_cnt_ff <= on_cnt_ff + 8'h01;
   end

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         string_en <= '0;
      else if (running && dim_s && !any_latch)
         string_en <= active_ch; // RL2 RL11
      else
         string_en <= '0; // RL2
   end

   // ----------------------------------------------------------------
   // Status
   // ----------------------------------------------------------------
   led_fault_pkg::fault_s nxt_flags;

   always_comb
   begin
      nxt_flags.open_string = open_now || (|ignore_ff) || all_open_ff;
      nxt_flags.led_short = |short_ff;
      nxt_flags.abnormal = abnormal_ff;
      nxt_flags.overvoltage = s.ovp_trip;
      nxt_flags.thermal = s.thermal;
      nxt_flags.diode_short = diode_short_ff;
      nxt_flags.vout_short = s.ovp_low && running;
   end

   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         fault_flags <= '0;
         status_n <= 1'b1;
      end
      else
      begin
         fault_flags <= nxt_flags;
         status_n <= !(en_s && (|nxt_flags)); // RL4 RL23
      end
   end

endmodule

/* logic/led_fault_pkg.sv */
// Shared constants and carrier types for the LED boost fault supervisor
package led_fault_pkg;

   localparam int unsigned NUM_CH = 4;
   localparam int unsigned CLK_HZ = 20000000;
   // Leading-edge blanking time in ns and its cycle count (least time, rounded up)
   localparam int unsigned BLANK_NS = 100;
   localparam int unsigned BLANK_CYC_RAW = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned BLANK_CYC = (BLANK_CYC_RAW < 1) ? 1 : BLANK_CYC_RAW;
   // Switching clocks the 0.8 V current flag must persist before latching
   localparam int unsigned SHORT_PERSIST = 16;
   // Soft-start ramp length in switching periods
   localparam int unsigned SOFT_PERIODS = 8;
   // Default switching period in system clocks (20 MHz / 40 = 500 kHz)
   localparam int unsigned SW_PERIOD_CYC = 40;
   // Default on-time at full drive, in system clocks
   localparam int unsigned SW_ON_CYC = 20;

   typedef logic [NUM_CH-1:0] ch_mask_t;

   // Comparator flags from the analog front end, all asynchronous
   typedef struct packed {
      logic ovp_trip;        // overvoltage_sense above 2.0 V (hysteresis in comparator)
      logic ovp_abnormal;    // overvoltage_sense above 3.2 V
      logic ovp_low;         // overvoltage_sense below 0.1 V
      logic cs_limit;        // switch current above 0.54 V
      logic cs_short;        // switch current above 0.8 V
      logic supply_lockout;  // internal supply low, hysteresis 3.6/3.8 V in comparator
      logic thermal;         // junction hot, hysteresis 160/140 C in comparator
      logic in_regulation;   // output back at regulated voltage
      logic led_min_ok;      // lowest_channel_voltage above 0.1 V
      ch_mask_t ch_high;     // channel sink above 7.3 V
      ch_mask_t ch_low;      // channel sink below 100 mV
   } sense_s;

   // Fault causes that pull the status output low
   typedef struct packed {
      logic open_string;
      logic led_short;
      logic abnormal;
      logic overvoltage;
      logic thermal;
      logic diode_short;
      logic vout_short;
   } fault_s;

   typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN, ST_LATCH} run_e;

endpackage

/* logic/sync_bank.sv */
// Two-flop synchroniser bank for asynchronous comparator flags
`timescale 1ns/1ps
module sync_bank #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic meta_ff;
         logic hold_ff;
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_ff <= 1'b0;
               hold_ff <= 1'b0;
            end
            else
            begin
               meta_ff <= async_in[g];
               hold_ff <= meta_ff;
            end
         end
         assign sync_out[g] = hold_ff;
      end
   endgenerate

endmodule
